// ===== cfg_regs_pkg.sv
// constants, types and register map of the monitor and converter config bank
package cfg_regs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MON = 8'h18;
  localparam logic [7:0] IDX_CONV = 8'h19;
  localparam logic [7:0] IDX_SPEED = 8'h1A;
  localparam logic [7:0] IDX_RANGE = 8'h1B;
  localparam logic [7:0] IDX_LOADCMD = 8'h1C;
  localparam logic [7:0] IDX_MSB_A = 8'h11;
  localparam logic [7:0] IDX_MSB_B = 8'h13;
  localparam logic [7:0] IDX_MSB_C = 8'h15;
  localparam logic [7:0] IDX_MSB_D = 8'h17;
  localparam logic [1:0] IDX_SHIFT = 2'h2;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] MON_WMASK = 8'h01;
  localparam logic [7:0] CONV_WMASK = 8'h7F;
  localparam logic [7:0] LOADCMD_RMASK = 8'h10;
  // field positions
  localparam int MON_EN_BIT = 0;
  localparam int CONV_CH_LSB = 0;
  localparam int CONV_SINGLE_BIT = 4;
  localparam int CONV_AVGDIS_BIT = 5;
  localparam int CONV_TMO_BIT = 6;
  localparam int CONV_SWRST_BIT = 7;
  localparam int SPEED_FAST_BIT = 0;
  localparam int SPEED_RES10_BIT = 1;
  localparam int SPEED_LDSRC_BIT = 3;
  localparam int SPEED_ATEMP_BIT = 5;
  localparam int SPEED_BTEMP_BIT = 6;
  localparam int RANGE_LSB = 0;
  localparam int GROUP_LSB = 4;
  localparam int BYP_AB_BIT = 6;
  localparam int BYP_CD_BIT = 7;
  localparam int LOADCMD_VREF_BIT = 4;
  // timing
  localparam longint CLK_HZ = 125000000;
  localparam int SCL_TMO_MS = 25;
  localparam int SCL_TMO_CYC = int'(CLK_HZ * SCL_TMO_MS / 1000);
  // adc clock rates in tenths of hertz: 1.4 kHz and 22.5 kHz
  localparam longint ADC_SLOW_DHZ = 14000;
  localparam longint ADC_FAST_DHZ = 225000;
  localparam int ADC_SLOW_CYC = int'(CLK_HZ * 10 / ADC_SLOW_DHZ);
  localparam int ADC_FAST_CYC = int'(CLK_HZ * 10 / ADC_FAST_DHZ);
  localparam int AVG_COUNT = 16;

  typedef enum logic [1:0] {
    CH_SUPPLY = 2'b00,
    CH_INT = 2'b01,
    CH_EXT = 2'b10,
    CH_RSVD = 2'b11
  } chan_t;

  typedef enum logic [1:0] {
    GRP_SINGLE = 2'b00,
    GRP_PAIR = 2'b01,
    GRP_ALL = 2'b10,
    GRP_CMD = 2'b11
  } group_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_WAIT = 1'b1
  } bus_state_t;

  typedef struct packed {
    logic monitor_en;
    chan_t channel_sel;
    logic single_channel;
    logic avg_disable;
    logic timeout_en;
    logic adc_fast;
    logic filter_disable;
    logic therm_10bit;
    logic load_by_reg;
    logic dac_a_temp;
    logic dac_b_temp;
    logic [3:0] dac_range;
    logic ref_bypass_ab;
    logic ref_bypass_cd;
    logic int_vref;
  } cfg_t;
endpackage

// ===== monitor_dac_config_regs.sv
// configuration register bank with ahb-lite slave, load control and conversion pacing
//
// What this block does
// RL1 - channel field picks supply, internal, external
// RL2 - cycle bit: round robin or single channel
// RL3 - sixteen-fold averaging unless disable bit set
// RL4 - timeout bit releases data after 25 ms
// RL5 - software reset restores every register default
// RL6 - speed bit: 1.4 or 22.5 kHz, filters
// RL7 - resolution bit picks 8 or 10 bit
// RL8 - host keeps resolution bit clear on 8-bit part
// RL9 - load source: strobe pin or registers
// RL10 - dac a follows internal temperature
// RL11 - dac b follows external temperature
// RL12 - host writes zero to reserved bits
// RL13 - range bits double each dac span
// RL14 - grouping 00: msb write loads that dac
// RL15 - grouping 01: b loads ab, d loads cd
// RL16 - grouping 10: only d write loads all
// RL17 - grouping 11: only load-command register loads
// RL18 - grouping acts only when pin disabled
// RL19 - bypass bits route reference around buffer
// RL20 - load-command bits pulse, read back zero
// RL21 - no conversions until monitoring enable set
// RL22 - software reset bit reads back cleared
`timescale 1ns/100ps
`default_nettype none

module monitor_dac_config_regs #(
  parameter int TMO_CYC = cfg_regs_pkg::SCL_TMO_CYC,
  parameter int ADC_SLOW_CYC = cfg_regs_pkg::ADC_SLOW_CYC,
  parameter int ADC_FAST_CYC = cfg_regs_pkg::ADC_FAST_CYC,
  parameter int AVG_COUNT = cfg_regs_pkg::AVG_COUNT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [cfg_regs_pkg::ADDR_W-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [cfg_regs_pkg::DATA_W-1:0] hwdata_i,
  input wire logic hready_i,
  output logic [cfg_regs_pkg::DATA_W-1:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic load_dac_strobe_n_i,
  input wire logic scl_i,
  output var cfg_regs_pkg::cfg_t cfg_o,
  output logic [3:0] dac_load_o,
  output logic soft_reset_o,
  output logic sda_release_o,
  output logic conv_start_o,
  output var cfg_regs_pkg::chan_t conv_channel_o
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  cfg_regs_pkg::bus_state_t state_q;
  logic [cfg_regs_pkg::ADDR_W-1:0] addr_q;
  logic wr_q;
  logic take;
  logic acc;
  logic wr_en;
  logic [7:0] wb;
  logic [7:0] idx;
  logic [7:0] mon_q;
  logic [7:0] conv_q;
  logic [7:0] speed_q;
  logic [7:0] range_q;
  logic vref_q;
  logic swrst;
  logic [3:0] msb_wr;
  logic cmd_wr;

  assign take = hsel_i && htrans_i[1] && hready_i;
  assign acc = (state_q == cfg_regs_pkg::BUS_WAIT);
  assign wr_en = acc && wr_q;
  assign wb = hwdata_i[7:0];
  assign idx = 8'(addr_q >> cfg_regs_pkg::IDX_SHIFT);

  // every transfer takes one wait state so writes and reads see settled data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= cfg_regs_pkg::BUS_IDLE;
      hreadyout_o <= 1'b1;
      addr_q <= '0;
      wr_q <= 1'b0;
    end else if (take) begin
      state_q <= cfg_regs_pkg::BUS_WAIT;
      hreadyout_o <= 1'b0;
      addr_q <= haddr_i;
      wr_q <= hwrite_i;
    end else begin
      state_q <= cfg_regs_pkg::BUS_IDLE;
      hreadyout_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
    end
  end

  // unmapped addresses read zero and ignore writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hrdata_o <= '0;
    end else if (acc && !wr_q) begin
      if (idx == cfg_regs_pkg::IDX_MON) begin
        hrdata_o <= 32'(mon_q);
      end else if (idx == cfg_regs_pkg::IDX_CONV) begin
        hrdata_o <= 32'(conv_q);
      end else if (idx == cfg_regs_pkg::IDX_SPEED) begin
        hrdata_o <= 32'(speed_q);
      end else if (idx == cfg_regs_pkg::IDX_RANGE) begin
        hrdata_o <= 32'(range_q);
      end else if (idx == cfg_regs_pkg::IDX_LOADCMD) begin
        hrdata_o <= 32'({3'h0, vref_q, 4'h0}); // RL20
      end else begin
        hrdata_o <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  assign swrst = wr_en && (idx == cfg_regs_pkg::IDX_CONV)
    && wb[cfg_regs_pkg::CONV_SWRST_BIT];
  assign cmd_wr = wr_en && (idx == cfg_regs_pkg::IDX_LOADCMD);
  assign msb_wr[0] = wr_en && (idx == cfg_regs_pkg::IDX_MSB_A);
  assign msb_wr[1] = wr_en && (idx == cfg_regs_pkg::IDX_MSB_B);
  assign msb_wr[2] = wr_en && (idx == cfg_regs_pkg::IDX_MSB_C);
  assign msb_wr[3] = wr_en && (idx == cfg_regs_pkg::IDX_MSB_D);

  always_ff @(posedge clk_i) begin
    if (rst_i || swrst) begin
      mon_q <= cfg_regs_pkg::REG_RESET; // RL5
    end else if (wr_en && idx == cfg_regs_pkg::IDX_MON) begin
      mon_q <= wb & cfg_regs_pkg::MON_WMASK;
    end
  end

  // reset bit is never stored, so it reads back as zero
  always_ff @(posedge clk_i) begin
    if (rst_i || swrst) begin
      conv_q <= cfg_regs_pkg::REG_RESET; // RL5 RL22
    end else if (wr_en && idx == cfg_regs_pkg::IDX_CONV) begin
      conv_q <= wb & cfg_regs_pkg::CONV_WMASK;
    end
  end

  // reserved bits are stored as written; keeping them zero is up to the host
  always_ff @(posedge clk_i) begin
    if (rst_i || swrst) begin
      speed_q <= cfg_regs_pkg::REG_RESET; // RL5
    end else if (wr_en && idx == cfg_regs_pkg::IDX_SPEED) begin
      speed_q <= wb;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || swrst) begin
      range_q <= cfg_regs_pkg::REG_RESET; // RL5
    end else if (wr_en && idx == cfg_regs_pkg::IDX_RANGE) begin
      range_q <= wb;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || swrst) begin
      vref_q <= 1'b0; // RL5
    end else if (cmd_wr) begin
      vref_q <= wb[cfg_regs_pkg::LOADCMD_VREF_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_reset_o <= 1'b0;
    end else begin
      soft_reset_o <= swrst; // RL5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration outputs

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o.monitor_en <= mon_q[cfg_regs_pkg::MON_EN_BIT]; // RL21
      cfg_o.channel_sel <= cfg_regs_pkg::chan_t'(conv_q[cfg_regs_pkg::CONV_CH_LSB +: 2]); // RL1
      cfg_o.single_channel <= conv_q[cfg_regs_pkg::CONV_SINGLE_BIT]; // RL2
      cfg_o.avg_disable <= conv_q[cfg_regs_pkg::CONV_AVGDIS_BIT]; // RL3
      cfg_o.timeout_en <= conv_q[cfg_regs_pkg::CONV_TMO_BIT]; // RL4
      cfg_o.adc_fast <= speed_q[cfg_regs_pkg::SPEED_FAST_BIT]; // RL6
      cfg_o.filter_disable <= speed_q[cfg_regs_pkg::SPEED_FAST_BIT]; // RL6
      cfg_o.therm_10bit <= speed_q[cfg_regs_pkg::SPEED_RES10_BIT]; // RL7
      cfg_o.load_by_reg <= speed_q[cfg_regs_pkg::SPEED_LDSRC_BIT]; // RL9
      cfg_o.dac_a_temp <= speed_q[cfg_regs_pkg::SPEED_ATEMP_BIT]; // RL10
      cfg_o.dac_b_temp <= speed_q[cfg_regs_pkg::SPEED_BTEMP_BIT]; // RL11
      cfg_o.dac_range <= range_q[cfg_regs_pkg::RANGE_LSB +: 4]; // RL13
      cfg_o.ref_bypass_ab <= range_q[cfg_regs_pkg::BYP_AB_BIT]; // RL19
      cfg_o.ref_bypass_cd <= range_q[cfg_regs_pkg::BYP_CD_BIT]; // RL19
      cfg_o.int_vref <= vref_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dac load commands

  logic strobe_prev_q;
  logic ext_fall;
  logic [3:0] load_d;
  cfg_regs_pkg::group_t group;

  assign group = cfg_regs_pkg::group_t'(range_q[cfg_regs_pkg::GROUP_LSB +: 2]);
  assign ext_fall = strobe_prev_q && !load_dac_strobe_n_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_prev_q <= 1'b1;
    end else begin
      strobe_prev_q <= load_dac_strobe_n_i;
    end
  end

  always_comb begin
    load_d = '0;
    if (!speed_q[cfg_regs_pkg::SPEED_LDSRC_BIT]) begin
      if (ext_fall) begin
        load_d = '1; // RL9
      end
    end else begin
      case (group) // RL18
        cfg_regs_pkg::GRP_SINGLE: begin
          load_d = msb_wr; // RL14
        end
        cfg_regs_pkg::GRP_PAIR: begin
          if (msb_wr[1]) begin
            load_d[1:0] = 2'h3; // RL15
          end
          if (msb_wr[3]) begin
            load_d[3:2] = 2'h3; // RL15
          end
        end
        cfg_regs_pkg::GRP_ALL: begin
          if (msb_wr[3]) begin
            load_d = '1; // RL16
          end
        end
        default: begin
          if (cmd_wr) begin
            load_d = wb[3:0]; // RL17 RL20
          end
        end
      endcase
    end
  end

  // a software reset drops any load in flight
  always_ff @(posedge clk_i) begin
    if (rst_i || swrst) begin
      dac_load_o <= '0;
    end else begin
      dac_load_o <= load_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial clock timeout

  logic [31:0] scl_cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || !conv_q[cfg_regs_pkg::CONV_TMO_BIT] || scl_i) begin
      scl_cnt_q <= '0;
      sda_release_o <= 1'b0; // RL4
    end else if (scl_cnt_q == 32'(TMO_CYC - 1)) begin
      sda_release_o <= 1'b1; // RL4
    end else begin
      scl_cnt_q <= scl_cnt_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion pacing and channel sequencing

  logic [31:0] div_q;
  logic [31:0] period;
  logic tick;
  logic [4:0] avg_q;
  logic [4:0] avg_last;
  logic mon_en;
  logic single;
  cfg_regs_pkg::chan_t sel;
  cfg_regs_pkg::chan_t cur_q;
  cfg_regs_pkg::chan_t first;
  cfg_regs_pkg::chan_t next_ch;

  assign mon_en = mon_q[cfg_regs_pkg::MON_EN_BIT];
  assign single = conv_q[cfg_regs_pkg::CONV_SINGLE_BIT];
  // reserved channel code falls back to the supply channel
  assign sel = (conv_q[cfg_regs_pkg::CONV_CH_LSB +: 2] == cfg_regs_pkg::CH_RSVD)
    ? cfg_regs_pkg::CH_SUPPLY
    : cfg_regs_pkg::chan_t'(conv_q[cfg_regs_pkg::CONV_CH_LSB +: 2]); // RL1
  assign first = single ? sel : cfg_regs_pkg::CH_SUPPLY; // RL2
  assign period = speed_q[cfg_regs_pkg::SPEED_FAST_BIT] ? 32'(ADC_FAST_CYC)
    : 32'(ADC_SLOW_CYC); // RL6
  assign tick = mon_en && (div_q >= period - 32'h1); // RL21
  assign avg_last = conv_q[cfg_regs_pkg::CONV_AVGDIS_BIT] ? 5'h0
    : 5'(AVG_COUNT - 1); // RL3

  always_comb begin
    next_ch = cfg_regs_pkg::CH_SUPPLY;
    if (single) begin
      next_ch = sel; // RL2
    end else begin
      case (cur_q)
        cfg_regs_pkg::CH_SUPPLY: next_ch = cfg_regs_pkg::CH_INT;
        cfg_regs_pkg::CH_INT: next_ch = cfg_regs_pkg::CH_EXT;
        default: next_ch = cfg_regs_pkg::CH_SUPPLY;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !mon_en) begin
      div_q <= '0; // RL21
    end else if (tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 32'h1;
    end
  end

  // one channel holds for a whole averaging run before moving on
  always_ff @(posedge clk_i) begin
    if (rst_i || !mon_en) begin
      avg_q <= '0;
      cur_q <= cfg_regs_pkg::CH_SUPPLY;
    end else if (tick) begin
      if (avg_q >= avg_last) begin
        avg_q <= '0; // RL3
        cur_q <= next_ch;
      end else begin
        avg_q <= avg_q + 5'h1;
      end
    end else if (avg_q == 5'h0 && single) begin
      cur_q <= first;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_start_o <= 1'b0;
      conv_channel_o <= cfg_regs_pkg::CH_SUPPLY;
    end else begin
      conv_start_o <= tick; // RL21
      if (tick) begin
        conv_channel_o <= cur_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic by_reg;
  assign by_reg = speed_q[cfg_regs_pkg::SPEED_LDSRC_BIT];

  sequence s_swrst_write;
    wr_en && idx == cfg_regs_pkg::IDX_CONV && wb[cfg_regs_pkg::CONV_SWRST_BIT];
  endsequence

  sequence s_defaults_back;
    conv_q == 8'h00 && speed_q == 8'h00 && range_q == 8'h00 && soft_reset_o
      ##1 cfg_o == '0;
  endsequence

  AST_SWRST_DEFAULTS: assert property (s_swrst_write |=> s_defaults_back) // RL5
    else $error("software reset left a register off its default");

  AST_SWRST_READS_ZERO: assert property (!conv_q[cfg_regs_pkg::CONV_SWRST_BIT]) // RL22
    else $error("software reset bit stored");

  AST_SWRST_READBACK: assert property (acc && !wr_q && idx == cfg_regs_pkg::IDX_CONV
    |=> !hrdata_o[cfg_regs_pkg::CONV_SWRST_BIT]) // RL22
    else $error("software reset bit read back as one");

  AST_PIN_LOADS_ALL: assert property (!by_reg && ext_fall && !swrst |=> dac_load_o == 4'hF) // RL9
    else $error("strobe pin edge did not load all dacs");

  AST_PIN_GATES_REGS: assert property (!by_reg && !ext_fall |=> dac_load_o == 4'h0) // RL18
    else $error("register load while strobe pin in control");

  AST_GROUP_SINGLE: assert property (by_reg && group == cfg_regs_pkg::GRP_SINGLE
    |=> dac_load_o == $past(msb_wr)) // RL14
    else $error("single grouping loaded wrong dacs");

  AST_GROUP_PAIR: assert property (by_reg && group == cfg_regs_pkg::GRP_PAIR && msb_wr[1]
    |=> dac_load_o == 4'h3) // RL15
    else $error("pair grouping did not load a and b");

  AST_GROUP_ALL: assert property (by_reg && group == cfg_regs_pkg::GRP_ALL && !msb_wr[3]
    |=> dac_load_o == 4'h0) // RL16
    else $error("all grouping loaded without a d write");

  AST_GROUP_CMD: assert property (by_reg && group == cfg_regs_pkg::GRP_CMD && !cmd_wr
    |=> dac_load_o == 4'h0) // RL17
    else $error("command grouping loaded without command write");

  AST_RANGE_FOLLOWS: assert property (wr_en && idx == cfg_regs_pkg::IDX_RANGE
    |=> ##1 cfg_o.dac_range == $past(wb[3:0], 2)) // RL13
    else $error("range outputs did not follow the write");

  AST_FAST_FILTER: assert property (cfg_o.adc_fast == cfg_o.filter_disable
    && cfg_o.filter_disable == $past(speed_q[cfg_regs_pkg::SPEED_FAST_BIT])) // RL6
    else $error("filter disable not tied to fast speed");

  AST_NO_CONV_STOPPED: assert property (!mon_en |=> !conv_start_o) // RL21
    else $error("conversion started while monitoring stopped");

  AST_TIMEOUT_OFF: assert property (!conv_q[cfg_regs_pkg::CONV_TMO_BIT] |=> !sda_release_o) // RL4
    else $error("data released with timeout disabled");

endmodule

`default_nettype wire

// ===== host_pins_model.sv
// host-side pin model: external load strobe and serial clock line
`timescale 1ns/100ps
`default_nettype none

module host_pins_model (
  input wire logic clk_i,
  output logic load_dac_strobe_n_o,
  output logic scl_o
);
  // both lines idle high; the clock line has a pull-up on the bus
  initial begin
    load_dac_strobe_n_o = 1'b1;
    scl_o = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // strobe low for two cycles; the falling edge is what counts
  task automatic strobe();
    @(posedge clk_i);
    load_dac_strobe_n_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    load_dac_strobe_n_o <= 1'b1;
  endtask

  // faulty master: clock held low for n cycles, then released
  task automatic scl_stuck(input int n);
    @(posedge clk_i);
    scl_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    scl_o <= 1'b1;
  endtask
endmodule

`default_nettype wire

// ===== monitor_dac_config_regs_test.sv
// self-checking bench for the monitor and converter configuration bank
`timescale 1ns/100ps
`default_nettype none

module monitor_dac_config_regs_test;
  localparam int TMO = 50;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [7:0] haddr_i = 8'h00;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o, rd;
  logic hreadyout_o, hresp_o, soft_reset_o, sda_release_o, conv_start_o, strobe_n, scl;
  logic [3:0] dac_load_o;
  logic [3:0] loads = 4'h0;
  logic [7:0] c, s, r;
  cfg_regs_pkg::cfg_t cfg_o;
  cfg_regs_pkg::chan_t conv_channel_o;
  cfg_regs_pkg::chan_t chq[$];
  int num_errors = 0;
  int n_checks = 0;
  int n_rst = 0;
  int nchg;

  always #4 clk_i = ~clk_i;

  // short counts keep the run brief
  monitor_dac_config_regs #(.TMO_CYC(TMO), .ADC_SLOW_CYC(20), .ADC_FAST_CYC(8),
    .AVG_COUNT(16)) dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .load_dac_strobe_n_i(strobe_n), .scl_i(scl), .cfg_o(cfg_o),
    .dac_load_o(dac_load_o), .soft_reset_o(soft_reset_o), .sda_release_o(sda_release_o),
    .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o));

  host_pins_model partner (.clk_i(clk_i), .load_dac_strobe_n_o(strobe_n), .scl_o(scl));

  // pulses are one cycle wide, so gather them here rather than poll
  always @(posedge clk_i) begin
    loads = loads | dac_load_o;
    if (soft_reset_o === 1'b1) n_rst++;
    if (conv_start_o === 1'b1) chq.push_back(conv_channel_o);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 20);
    if (hreadyout_o !== 1'b1) begin
      num_errors++;
      stop_test();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= 2'h2;
    wait_rdy();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_rdy();
    rd = hrdata_o;
    chk(32'(hresp_o), 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // scl held low past the limit; release level is expected value e
  task automatic tmo_run(input logic e);
    fork
      partner.scl_stuck(TMO + 20);
      begin
        repeat (TMO - 10) @(posedge clk_i);
        chk(32'(sda_release_o), 32'h0);
        repeat (22) @(posedge clk_i);
        chk(32'(sda_release_o), 32'(e));
      end
    join
    repeat (4) @(posedge clk_i);
    chk(32'(sda_release_o), 32'h0);
  endtask

  task automatic conv_run(input int cyc);
    repeat (4) @(posedge clk_i);
    chq.delete();
    repeat (cyc) @(posedge clk_i);
    nchg = 0;
    for (int i = 1; i < chq.size(); i++) if (chq[i] != chq[i-1]) nchg++;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  function automatic cfg_regs_pkg::cfg_t exp_cfg(input logic m, input logic [7:0] c, s, r);
    cfg_regs_pkg::cfg_t e;
    e = '0;
    e.monitor_en = m;
    e.channel_sel = cfg_regs_pkg::chan_t'(c[1:0]);
    e.single_channel = c[4];
    e.avg_disable = c[5];
    e.timeout_en = c[6];
    e.adc_fast = s[0];
    e.filter_disable = s[0];
    e.therm_10bit = s[1];
    e.load_by_reg = s[3];
    e.dac_a_temp = s[5];
    e.dac_b_temp = s[6];
    e.dac_range = r[3:0];
    e.ref_bypass_ab = r[6];
    e.ref_bypass_cd = r[7];
    return e;
  endfunction

  function automatic logic [3:0] exp_load(input logic [1:0] g, input int d);
    case (g)
      2'b00: return 4'h1 << d;
      2'b01: return (d == 1) ? 4'h3 : ((d == 3) ? 4'hC : 4'h0);
      2'b10: return (d == 3) ? 4'hF : 4'h0;
      default: return 4'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rd = $urandom(47);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'(cfg_o), 32'h0);
    for (int i = 0; i < 4; i++) rdc(8'h60 + 8'(4 * i), 32'h0);
    wr(8'h04, 32'hFF);
    rdc(8'h04, 32'h0);
    conv_run(60);
    chk(32'(chq.size()), 32'h0);
    for (int i = 0; i < 12; i++) begin
      c = (i == 0) ? 8'h7F : 8'($urandom) & 8'h7F;
      s = (i == 0) ? 8'h6B : 8'($urandom) & 8'h6B;
      r = (i == 0) ? 8'hFF : 8'($urandom);
      wr(8'h64, 32'(c));
      wr(8'h68, 32'(s));
      wr(8'h6C, 32'(r));
      rdc(8'h64, 32'(c));
      rdc(8'h68, 32'(s));
      rdc(8'h6C, 32'(r));
      chk(32'(cfg_o), 32'(exp_cfg(1'b0, c, s, r)));
    end
    wr(8'h60, 32'h1);
    wr(8'h64, 32'h80);
    repeat (3) @(posedge clk_i);
    chk(32'(n_rst), 32'h1);
    for (int i = 0; i < 4; i++) rdc(8'h60 + 8'(4 * i), 32'h0);
    chk(32'(cfg_o), 32'h0);
    // register-driven loading, every grouping code
    wr(8'h68, 32'h08);
    for (int g = 0; g < 4; g++) begin
      wr(8'h6C, 32'(g << 4));
      for (int d = 0; d < 4; d++) begin
        loads = 4'h0;
        wr(8'h44 + 8'(8 * d), $urandom);
        repeat (2) @(posedge clk_i);
        chk(32'(loads), 32'(exp_load(2'(g), d)));
      end
      loads = 4'h0;
      wr(8'h70, 32'h1F);
      repeat (2) @(posedge clk_i);
      chk(32'(loads), (g == 3) ? 32'hF : 32'h0);
      rdc(8'h70, 32'h10);
    end
    loads = 4'h0;
    partner.strobe();
    repeat (6) @(posedge clk_i);
    chk(32'(loads), 32'h0);
    // pin-driven loading: register writes must not load
    wr(8'h68, 32'h00);
    wr(8'h6C, 32'h00);
    loads = 4'h0;
    wr(8'h44, 32'h5A);
    repeat (2) @(posedge clk_i);
    chk(32'(loads), 32'h0);
    partner.strobe();
    repeat (6) @(posedge clk_i);
    chk(32'(loads), 32'hF);
    wr(8'h64, 32'h40);
    tmo_run(1'b1);
    wr(8'h64, 32'h00);
    tmo_run(1'b0);
    // single channel: external source fast, then internal source slow
    wr(8'h64, 32'h32);
    wr(8'h68, 32'h01);
    wr(8'h60, 32'h01);
    conv_run(160);
    chk(32'(chq.size() inside {[19:21]}), 32'h1);
    foreach (chq[i]) chk(32'(chq[i]), 32'(cfg_regs_pkg::CH_EXT));
    wr(8'h64, 32'h31);
    wr(8'h68, 32'h00);
    conv_run(160);
    chk(32'(chq.size() inside {[7:9]}), 32'h1);
    foreach (chq[i]) chk(32'(chq[i]), 32'(cfg_regs_pkg::CH_INT));
    // round robin without and with averaging
    wr(8'h64, 32'h20);
    wr(8'h68, 32'h01);
    conv_run(160);
    chk(32'(nchg), 32'(chq.size() - 1));
    wr(8'h64, 32'h00);
    conv_run(320);
    chk(32'(nchg inside {[1:3]}), 32'h1);
    stop_test();
  end

  initial begin
    #800000;
    num_errors++;
    stop_test();
  end
endmodule

`default_nettype wire
